// ### common/wiper_pair_pkg.sv
// constants and types for the addressable wiper register pair
package wiper_pair_pkg;

  localparam int          DATA_W        = 8;
  localparam int          SEL_W         = 3;
  localparam int          CODE_W        = 4;
  localparam int          CNT_W         = 4;
  // bit counter values inside one byte slot
  localparam logic [3:0]  CNT_LAST_BIT  = 4'h7;
  localparam logic [3:0]  CNT_ACK       = 4'h8;
  localparam logic [3:0]  CNT_DONE      = 4'h9;
  // control byte layout
  localparam int          CODE_MSB      = 7;
  localparam int          CODE_LSB      = 4;
  localparam int          SEL_MSB       = 3;
  localparam int          SEL_LSB       = 1;
  localparam int          DIR_BIT       = 0;
  localparam logic        DIR_READ      = 1'b1;
  // register reset values and register index codes
  localparam logic [7:0]  WIPER_RESET   = 8'h00;
  localparam logic [7:0]  SCRATCH_RESET = 8'h00;
  localparam logic        REG_SCRATCH   = 1'b0;
  localparam logic        REG_WIPER     = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_WRITE,
    ST_READ
  } link_state_t;

  typedef struct packed {
    logic        scl_s1;
    logic        scl_s2;
    logic        scl_d;
    logic        sda_s1;
    logic        sda_s2;
    logic        sda_d;
    logic [2:0]  sel_s1;
    logic [2:0]  sel_s2;
    link_state_t state;
    logic [3:0]  bit_cnt;
    logic [7:0]  shift;
    logic        rw;
    logic        reg_idx;
    logic [7:0]  scratch;
    logic [7:0]  wiper;
    logic        sda_oe_n;
    logic        sda_out;
  } pot_state_t;

endpackage

// ### logic/wiper_register_pair.sv
// two-wire slave holding the scratch byte and the wiper position byte
//
// What this block does
// - exactly two 8-bit registers, both written and read over the link
// - scratch byte only stores the last written value
// - wiper byte directly selects one of 256 taps
// - 00h selects low terminal, FFh one step below high terminal
// - wiper clears to 00h at power-up until written
// - three select pins give the device its bus address bits
// - link is one two-way data line and a master-driven clock
// - control byte is device code, three select bits, direction bit
// - direction bit one means read, zero means write
// - reads return scratch byte first, then wiper byte, MSB first
// - every byte travels most significant bit first, both directions
`timescale 1ns/10ps
module wiper_register_pair
  import wiper_pair_pkg::*;
#(
  // device-type code, value arbitrary
  parameter logic [3:0] DEVICE_CODE = 4'b1010
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             scl_in,
  input  wire logic             sda_in,
  output logic                  sda_out,
  output logic                  sda_oe_n,
  input  wire logic [SEL_W-1:0] bus_select_pins,
  output logic [DATA_W-1:0]     wiper_tap
);

  pot_state_t state_reg;
  pot_state_t state_next;

  logic             scl_rise;
  logic             scl_fall;
  logic             start_seen;
  logic             stop_seen;
  logic [7:0]       rx_byte;
  logic             addr_hit;

  assign scl_rise   = state_reg.scl_s2 & ~state_reg.scl_d;
  assign scl_fall   = ~state_reg.scl_s2 & state_reg.scl_d;
  assign start_seen = state_reg.scl_s2 & state_reg.scl_d
                      & state_reg.sda_d & ~state_reg.sda_s2;
  assign stop_seen  = state_reg.scl_s2 & state_reg.scl_d
                      & ~state_reg.sda_d & state_reg.sda_s2;
  assign rx_byte    = {state_reg.shift[6:0], state_reg.sda_s2};
  // code, then select bits matched against the pins
  assign addr_hit   = (rx_byte[CODE_MSB:CODE_LSB] == DEVICE_CODE)
                      && (rx_byte[SEL_MSB:SEL_LSB] == state_reg.sel_s2);

  always_comb begin
    state_next        = state_reg;
    // clock and data pins are foreign, so two flops each
    state_next.scl_s1 = scl_in;
    state_next.scl_s2 = state_reg.scl_s1;
    state_next.scl_d  = state_reg.scl_s2;
    state_next.sda_s1 = sda_in;
    state_next.sda_s2 = state_reg.sda_s1;
    state_next.sda_d  = state_reg.sda_s2;
    // select pins may change while powered, so track them
    state_next.sel_s1 = bus_select_pins;
    state_next.sel_s2 = state_reg.sel_s1;
    state_next.sda_out = 1'b0;

    // start and stop win over any bit activity in the same cycle
    if (start_seen) begin
      state_next.state    = ST_ADDR;
      state_next.bit_cnt  = '0;
      state_next.sda_oe_n = 1'b1;
    end else if (stop_seen) begin
      state_next.state    = ST_IDLE;
      state_next.sda_oe_n = 1'b1;
    end else if (scl_rise && state_reg.state != ST_IDLE) begin
      if (state_reg.bit_cnt != CNT_DONE) begin
        state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
      end
      case (state_reg.state)
        ST_ADDR: begin
          if (state_reg.bit_cnt < CNT_ACK) begin
            state_next.shift = rx_byte;
          end
          if (state_reg.bit_cnt == CNT_LAST_BIT) begin
            if (addr_hit) begin
              // low bit picks read or write
              state_next.rw      = rx_byte[DIR_BIT];
              state_next.reg_idx = REG_SCRATCH;
            end else begin
              state_next.state = ST_IDLE;
            end
          end
        end
        ST_WRITE: begin
          if (state_reg.bit_cnt < CNT_ACK) begin
            state_next.shift = rx_byte;
          end
          // commit only once the whole byte is in
          if (state_reg.bit_cnt == CNT_LAST_BIT) begin
            state_next.reg_idx = ~state_reg.reg_idx;
            // scratch byte just holds the value
            if (state_reg.reg_idx == REG_SCRATCH) begin
              state_next.scratch = rx_byte;
            end else begin
              // byte value is the tap number
              state_next.wiper = rx_byte;
            end
          end
        end
        ST_READ: begin
          // a master nack ends the read; wait for stop
          if (state_reg.bit_cnt == CNT_ACK && state_reg.sda_s2) begin
            state_next.state = ST_IDLE;
          end
        end
        default: state_next.state = ST_IDLE;
      endcase
    end else if (scl_fall && state_reg.state != ST_IDLE) begin
      case (state_reg.state)
        ST_ADDR, ST_WRITE: begin
          if (state_reg.bit_cnt == CNT_ACK) begin
            state_next.sda_oe_n = 1'b0;
          end else if (state_reg.bit_cnt == CNT_DONE) begin
            state_next.bit_cnt = '0;
            if (state_reg.state == ST_ADDR && state_reg.rw == DIR_READ) begin
              state_next.state    = ST_READ;
              state_next.shift    = state_reg.scratch;
              state_next.sda_oe_n = state_reg.scratch[7];
              state_next.reg_idx  = REG_WIPER;
            end else begin
              state_next.state    = ST_WRITE;
              state_next.sda_oe_n = 1'b1;
            end
          end
        end
        ST_READ: begin
          if (state_reg.bit_cnt == CNT_ACK) begin
            state_next.sda_oe_n = 1'b1;
          end else if (state_reg.bit_cnt == CNT_DONE) begin
            // alternate scratch and wiper while the master acks
            state_next.bit_cnt = '0;
            state_next.reg_idx = ~state_reg.reg_idx;
            if (state_reg.reg_idx == REG_WIPER) begin
              state_next.shift    = state_reg.wiper;
              state_next.sda_oe_n = state_reg.wiper[7];
            end else begin
              state_next.shift    = state_reg.scratch;
              state_next.sda_oe_n = state_reg.scratch[7];
            end
          end else if (state_reg.bit_cnt != '0) begin
            // next lower bit goes out after each clock
            state_next.shift    = {state_reg.shift[6:0], 1'b0};
            state_next.sda_oe_n = state_reg.shift[6];
          end
        end
        default: state_next.state = ST_IDLE;
      endcase
    end

    if (state_next.state == ST_IDLE) begin
      state_next.sda_oe_n = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg          <= '0;
      state_reg.scl_s1   <= 1'b1;
      state_reg.scl_s2   <= 1'b1;
      state_reg.scl_d    <= 1'b1;
      state_reg.sda_s1   <= 1'b1;
      state_reg.sda_s2   <= 1'b1;
      state_reg.sda_d    <= 1'b1;
      state_reg.state    <= ST_IDLE;
      state_reg.sda_oe_n <= 1'b1;
      state_reg.scratch  <= SCRATCH_RESET;
      // wiper starts at the low terminal
      state_reg.wiper    <= WIPER_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // tap number drives the array select as is
  assign wiper_tap = state_reg.wiper;
  assign sda_oe_n  = state_reg.sda_oe_n;
  assign sda_out   = state_reg.sda_out;

  sequence addr_byte_done;
    state_reg.state == ST_ADDR && scl_rise && !start_seen && !stop_seen
      && state_reg.bit_cnt == CNT_LAST_BIT;
  endsequence

  sequence write_byte_done;
    state_reg.state == ST_WRITE && scl_rise && !start_seen && !stop_seen
      && state_reg.bit_cnt == CNT_LAST_BIT;
  endsequence

  chk_wiper_reset_low: assert property (@(posedge clk)
    !rst_b |=> wiper_tap == WIPER_RESET)
    else $error("wiper not cleared by reset");

  chk_wiper_whole_byte: assert property (@(posedge clk)
    disable iff (!rst_b)
    $changed(wiper_tap) |-> $past(state_reg.state == ST_WRITE && scl_rise
      && state_reg.bit_cnt == CNT_LAST_BIT && state_reg.reg_idx))
    else $error("wiper changed outside a completed wiper byte");

  chk_wiper_takes_byte: assert property (@(posedge clk)
    disable iff (!rst_b)
    write_byte_done ##0 (state_reg.reg_idx == REG_WIPER)
      |=> wiper_tap == $past(rx_byte))
    else $error("wiper did not take the received byte");

  chk_scratch_no_tap: assert property (@(posedge clk)
    disable iff (!rst_b)
    write_byte_done ##0 (state_reg.reg_idx == REG_SCRATCH)
      |=> state_reg.scratch == $past(rx_byte) && $stable(wiper_tap))
    else $error("scratch write misrouted");

  chk_addr_miss_idle: assert property (@(posedge clk)
    disable iff (!rst_b)
    addr_byte_done ##0 !addr_hit |=> state_reg.state == ST_IDLE
      ##1 sda_oe_n [*3])
    else $error("device answered a foreign address");

  chk_dir_bit_read: assert property (@(posedge clk)
    disable iff (!rst_b)
    addr_byte_done ##0 addr_hit |=> state_reg.rw == $past(rx_byte[0]))
    else $error("direction bit not captured");

  chk_read_first_byte: assert property (@(posedge clk)
    disable iff (!rst_b)
    state_reg.state == ST_ADDR ##1 state_reg.state == ST_READ
      |-> state_reg.shift == state_reg.scratch)
    else $error("read did not start with scratch byte");

  chk_read_msb_first: assert property (@(posedge clk)
    disable iff (!rst_b)
    state_reg.state == ST_READ && state_reg.bit_cnt < CNT_ACK
      |-> sda_oe_n == state_reg.shift[7])
    else $error("read bit order wrong");

  chk_idle_released: assert property (@(posedge clk)
    disable iff (!rst_b)
    state_reg.state == ST_IDLE |-> sda_oe_n && !sda_out)
    else $error("data line driven while idle");

endmodule

// ### test/addressable_wiper_register_pair_tb.sv
// self-checking bench for the wiper register pair
`timescale 1ns/10ps
`define CHK(got, exp) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
module addressable_wiper_register_pair_tb;
  import wiper_pair_pkg::*;
  // device-type code, value arbitrary
  localparam logic [3:0] CODE = 4'h9;
  typedef struct packed {
    logic [7:0] scr;
    logic [7:0] wip;
    logic [2:0] sel;
  } row_t;
  logic       clk;
  logic       rst_b;
  logic [2:0] sel;
  logic       scl;
  logic       sda_drv;
  logic       sda_wire;
  logic       sda_out;
  logic       sda_oe_n;
  logic [7:0] wiper_tap;
  logic [7:0] rx;
  logic       ak;
  int         error_cnt = 0;
  int         check_count = 0;
  int         cyc = 0;
  // each row also sets the select pins, so every select bit is exercised
  row_t rows [4] = '{'{8'h00, 8'hFF, 3'h0}, '{8'hFF, 8'h00, 3'h7},
                     '{8'hA5, 8'h5A, 3'h5}, '{8'h3C, 8'h01, 3'h6}};
  // pull-up wire: low when either party pulls it
  assign sda_wire = sda_drv & (sda_oe_n | sda_out);
  wiper_register_pair #(.DEVICE_CODE(CODE)) dut_u (
    .clk             (clk),
    .rst_b           (rst_b),
    .scl_in          (scl),
    .sda_in          (sda_wire),
    .sda_out         (sda_out),
    .sda_oe_n        (sda_oe_n),
    .bus_select_pins (sel),
    .wiper_tap       (wiper_tap)
  );
  bus_master_model m_u (
    .clk      (clk),
    .sda_wire (sda_wire),
    .scl      (scl),
    .sda_drv  (sda_drv)
  );
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] ctl, d0, d1, input logic ok);
    m_u.frame(1'b0);
    m_u.xfer(ctl, 1'b1, rx, ak);
    `CHK(ak, !ok)
    if (ok) begin
      m_u.xfer(d0, 1'b1, rx, ak);
      `CHK(ak, 1'b0)
      m_u.xfer(d1, 1'b1, rx, ak);
      `CHK(ak, 1'b0)
    end
    m_u.frame(1'b1);
  endtask
  // reads both bytes, master nacks the second one
  task automatic rd(input logic [7:0] e0, e1);
    m_u.frame(1'b0);
    m_u.xfer({CODE, sel, 1'b1}, 1'b1, rx, ak);
    `CHK(ak, 1'b0)
    m_u.xfer(8'hFF, 1'b0, rx, ak);
    `CHK(rx, e0)
    m_u.xfer(8'hFF, 1'b1, rx, ak);
    `CHK(rx, e1)
    m_u.frame(1'b1);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    rst_b <= 1'b0;
    sel   <= 3'h0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(wiper_tap, WIPER_RESET)
    `CHK(sda_out, 1'b0)
    `CHK(sda_oe_n, 1'b1)
    rd(SCRATCH_RESET, WIPER_RESET);
    foreach (rows[i]) begin
      sel <= rows[i].sel;
      wr({CODE, rows[i].sel, 1'b0}, rows[i].scr, rows[i].wip, 1'b1);
      `CHK(wiper_tap, rows[i].wip)
      rd(rows[i].scr, rows[i].wip);
    end
    // foreign select bits and foreign code must both be ignored
    wr({CODE, sel ^ 3'h1, 1'b0}, 8'h11, 8'h22, 1'b0);
    wr({CODE ^ 4'h1, sel, 1'b0}, 8'h11, 8'h22, 1'b0);
    `CHK(wiper_tap, 8'h01)
    sel <= 3'h2;
    m_u.pace = 10;
    wr({CODE, 3'h2, 1'b0}, 8'h77, 8'hC3, 1'b1);
    `CHK(wiper_tap, 8'hC3)
    m_u.pace = 4;
    // wiper byte cut after four bits by a stop
    m_u.frame(1'b0);
    m_u.xfer({CODE, sel, 1'b0}, 1'b1, rx, ak);
    m_u.xfer(8'h99, 1'b1, rx, ak);
    for (int i = 0; i < 4; i++) begin
      m_u.bit_io(1'b1, ak);
    end
    m_u.frame(1'b1);
    `CHK(wiper_tap, 8'hC3)
    rd(8'h99, 8'hC3);
    // single scratch write, then repeated start straight into a read
    m_u.frame(1'b0);
    m_u.xfer({CODE, sel, 1'b0}, 1'b1, rx, ak);
    m_u.xfer(8'h10, 1'b1, rx, ak);
    rd(8'h10, 8'hC3);
    // a third written byte wraps back to the scratch byte
    m_u.frame(1'b0);
    m_u.xfer({CODE, sel, 1'b0}, 1'b1, rx, ak);
    m_u.xfer(8'h21, 1'b1, rx, ak);
    m_u.xfer(8'h42, 1'b1, rx, ak);
    m_u.xfer(8'h63, 1'b1, rx, ak);
    `CHK(ak, 1'b0)
    m_u.frame(1'b1);
    `CHK(wiper_tap, 8'h42)
    // three-byte read: scratch, wiper, then scratch again
    m_u.frame(1'b0);
    m_u.xfer({CODE, sel, 1'b1}, 1'b1, rx, ak);
    m_u.xfer(8'hFF, 1'b0, rx, ak);
    `CHK(rx, 8'h63)
    m_u.xfer(8'hFF, 1'b0, rx, ak);
    `CHK(rx, 8'h42)
    m_u.xfer(8'hFF, 1'b1, rx, ak);
    `CHK(rx, 8'h63)
    m_u.frame(1'b1);
    // reset in mid-run, bus idle, brings both bytes back
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(wiper_tap, WIPER_RESET)
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(sda_oe_n, 1'b1)
    rd(SCRATCH_RESET, WIPER_RESET);
    print_verdict();
  end
endmodule

// ### test/bus_master_model.sv
// two-wire bus master model that drives the device's serial link
`timescale 1ns/10ps
module bus_master_model (
  input  wire logic clk,
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_drv
);
  // clocks per quarter bit; raise it to play a slow master
  int pace = 4;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    wt(pace);
    sda_drv <= b;
    wt(pace);
    scl <= 1'b1;
    wt(pace);
    r = sda_wire;
    wt(pace);
    scl <= 1'b0;
  endtask
  // start (also repeated) or stop: sda is preset before scl rises, then toggles while scl is high
  task automatic frame(input logic is_stop);
    wt(pace);
    sda_drv <= !is_stop;
    wt(pace);
    scl <= 1'b1;
    wt(2 * pace);
    sda_drv <= is_stop;
    wt(2 * pace);
    if (!is_stop) begin
      scl <= 1'b0;
    end
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack_in, ack);
  endtask
endmodule
